// File: logic/ras_pkg.sv
// Contract
// - program memory 32 or 16 Kbytes by variant
// - unimplemented program space reads as zero
// - 31 entries of 21 bits, 5-bit pointer
// - push, call, relative_call, interrupt push pc
// - returns pop top into pc, latches untouched
// - every reset clears pointer; zero has no entry
// - push increments pointer then writes entry
// - pop reads entry then decrements pointer
// - three byte registers access top entry
// - software reads and writes pointer directly
// - full flag after 31 pushes without pop
// - overflow reset on: store pc+2, reset, pointer 0
// - overflow reset off: pointer 31, overwrite top
// - return at zero gives zero, underflow flag
// - flag first, then reset only when enabled
// - flags survive all but power-on reset
// - full bit7, underflow bit6, bit5 zero, pointer 4-0
// - pop instruction just decrements pointer
// - shadow captured on interrupt, not software visible
// - fast return restores shadow
// - both interrupt priorities capture shadow
// - fast call captures shadow
// - address zero is the reset vector
package ras_pkg;
  localparam int PC_W = 21;
  localparam int SP_W = 5;
  localparam int DEPTH = 31;
  localparam logic [SP_W-1:0] SP_MAX = 5'h1f;
  localparam logic [SP_W-1:0] SP_RST = 5'h00;
  localparam logic [PC_W-1:0] RESET_VEC = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] MEM_BIG = 21'h008000;
  localparam logic [PC_W-1:0] MEM_SMALL = 21'h004000;
  localparam int FULL_BIT = 7;
  localparam int UNF_BIT = 6;
  // word byte addresses of the register window
  localparam logic [3:0] ADR_PTR = 4'h0;
  localparam logic [3:0] ADR_TOP_ENTRY_LOW = 4'h4;
  localparam logic [3:0] ADR_TOP_ENTRY_HIGH = 4'h8;
  localparam logic [3:0] ADR_TOP_ENTRY_UPPER = 4'hc;
  localparam logic [31:0] RD_ZERO = 32'h00000000;

  typedef struct packed {
    logic push;       // push / call / relative_call
    logic irq_ack;    // interrupt acknowledged
    logic ret;        // return / literal / from interrupt
    logic pop;        // pop instruction
    logic fast;       // fast option with call or return
    logic [PC_W-1:0] pc;
  } ras_op_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] working_reg;
    logic [7:0] bank_select_reg;
  } ras_shadow_t;
endpackage : ras_pkg

// File: logic/ras_stack.sv
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module ras_stack (
  input wire logic mclk, // core clock 20 mhz
  input wire logic rst, // any reset, sync active high
  input wire logic por, // power-on reset, sync active high
  input wire logic overflow_reset_en, // stack_overflow_reset_en config
  input wire logic big_mem, // 1 = 32 kbyte variant
  input wire ras_pkg::ras_op_t op, // sequencer request
  input wire ras_pkg::ras_shadow_t live_regs, // status, working_reg, bsr now
  output ras_pkg::ras_shadow_t shadow_out, // fast restore values
  output logic restore_shadow, // pulse: load shadow_out
  output logic [ras_pkg::PC_W-1:0] pc_load, // popped pc
  output logic pc_load_valid, // pulse: pc_load valid
  output logic stack_reset_req, // pulse: request device reset
  input wire logic [ras_pkg::PC_W-1:0] prog_addr, // fetch address
  input wire logic [15:0] prog_rdata, // flash word
  output logic [15:0] prog_data, // zero filled fetch data
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_adr_i, // byte address
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o // ack
);
  import ras_pkg::*;

  logic [PC_W-1:0] mem [1:DEPTH]; // no storage behind zero
  logic [SP_W-1:0] sp_ff;
  logic full_ff;
  logic unf_ff;
  ras_shadow_t shadow_ff;
  logic [PC_W-1:0] pc_ff;
  logic pcv_ff;
  logic rstreq_ff;
  logic restore_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [15:0] pdat_ff;
  logic [PC_W-1:0] top;
  logic do_push;
  logic do_pop;
  logic wb_req;
  logic wb_wr;
  logic in_win;
  logic wr_ptr;
  logic wr_top_entry_low;
  logic wr_top_entry_high;
  logic wr_top_entry_upper;
  logic [SP_W-1:0] nxt_sp;
  logic [PC_W-1:0] push_val;
  logic push_full;
  logic pop_unf;
  logic [PC_W-1:0] mem_lim;

  assign top = (sp_ff == SP_RST) ? RESET_VEC : mem[sp_ff];
  assign do_push = op.push | op.irq_ack;
  assign do_pop = op.ret | op.pop;
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  // only the low 16 bytes decode; anything above must not alias
  assign in_win = (wb_adr_i[31:4] == 28'h0000000);
  // writes land at the edge where the master samples ack high
  assign wb_wr = wb_cyc_i & wb_stb_i & ack_ff & wb_we_i &
    wb_sel_i[0] & in_win;
  assign wr_ptr = wb_wr & (wb_adr_i[3:0] == ADR_PTR);
  assign wr_top_entry_low = wb_wr & (wb_adr_i[3:0] == ADR_TOP_ENTRY_LOW);
  assign wr_top_entry_high = wb_wr & (wb_adr_i[3:0] == ADR_TOP_ENTRY_HIGH);
  assign wr_top_entry_upper = wb_wr & (wb_adr_i[3:0] == ADR_TOP_ENTRY_UPPER);
  // 31st push counts from a pointer of 30
  assign push_full = do_push & (sp_ff >= (SP_MAX - 5'h01));
  assign pop_unf = do_pop & (sp_ff == SP_RST);
  // with reset on, the full push stores the next pc
  assign push_val = (push_full & overflow_reset_en & sp_ff != SP_MAX) ?
    op.pc + PC_STEP : op.pc;

  // pointer next value; push takes priority over a pop
  always_comb
  begin
    nxt_sp = sp_ff;
    if (do_push)
    begin
      if (sp_ff != SP_MAX)
        nxt_sp = sp_ff + 5'h01;
    end
    else if (do_pop)
    begin
      if (sp_ff != SP_RST)
        nxt_sp = sp_ff - 5'h01;
    end
    else if (wr_ptr)
      nxt_sp = wb_dat_i[SP_W-1:0];
  end

  // pointer; every reset clears it
  always_ff @(posedge mclk)
  begin
    if (rst)
      sp_ff <= SP_RST;
    else
      sp_ff <= nxt_sp;
  end

  // stack entries; push writes the slot at the new pointer
  always_ff @(posedge mclk)
  begin
    if (do_push)
      mem[nxt_sp] <= push_val;
    else if (sp_ff != SP_RST)
    begin
      if (wr_top_entry_low)
        mem[sp_ff][7:0] <= wb_dat_i[7:0];
      if (wr_top_entry_high)
        mem[sp_ff][15:8] <= wb_dat_i[7:0];
      if (wr_top_entry_upper)
        mem[sp_ff][20:16] <= wb_dat_i[4:0];
    end
  end

  // flags survive ordinary resets; set beats a software clear
  always_ff @(posedge mclk)
  begin
    if (por)
    begin
      full_ff <= 1'b0;
      unf_ff <= 1'b0;
    end
    else
    begin
      if (push_full)
        full_ff <= 1'b1;
      else if (wr_ptr & ~wb_dat_i[FULL_BIT])
        full_ff <= 1'b0;
      if (pop_unf & op.ret)
        unf_ff <= 1'b1;
      else if (wr_ptr & ~wb_dat_i[UNF_BIT])
        unf_ff <= 1'b0;
    end
  end

  // popped pc to the sequencer; latches are not driven here
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pc_ff <= RESET_VEC;
      pcv_ff <= 1'b0;
    end
    else
    begin
      pcv_ff <= op.ret & ~do_push;
      pc_ff <= top;
    end
  end

  // device reset request registered on the same edge that sets the flag
  always_ff @(posedge mclk)
  begin
    if (rst)
      rstreq_ff <= 1'b0;
    else
      rstreq_ff <= overflow_reset_en &
        ((push_full & sp_ff != SP_MAX) | (pop_unf & op.ret));
  end

  // one-level shadow, invisible to software
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      shadow_ff <= '0;
      restore_ff <= 1'b0;
    end
    else
    begin
      if (op.irq_ack | (op.push & op.fast))
        shadow_ff <= live_regs;
      restore_ff <= op.ret & op.fast & ~do_push;
    end
  end

  // zero fill above the implemented flash
  assign mem_lim = big_mem ? MEM_BIG : MEM_SMALL;
  always_ff @(posedge mclk)
  begin
    if (rst)
      pdat_ff <= 16'h0000;
    else if (prog_addr >= mem_lim)
      pdat_ff <= 16'h0000;
    else
      pdat_ff <= prog_rdata;
  end

  // wishbone read data; unmapped reads return zero
  always_ff @(posedge mclk)
  begin
    if (rst)
      rdat_ff <= RD_ZERO;
    else if (wb_req & ~wb_we_i)
    begin
      if (!in_win)
        rdat_ff <= RD_ZERO;
      else if (wb_adr_i[3:0] == ADR_PTR)
        rdat_ff <= {24'h000000, full_ff, unf_ff, 1'b0, sp_ff};
      else if (wb_adr_i[3:0] == ADR_TOP_ENTRY_LOW)
        rdat_ff <= {24'h000000, top[7:0]};
      else if (wb_adr_i[3:0] == ADR_TOP_ENTRY_HIGH)
        rdat_ff <= {24'h000000, top[15:8]};
      else if (wb_adr_i[3:0] == ADR_TOP_ENTRY_UPPER)
        rdat_ff <= {27'h0000000, top[20:16]};
      else
        rdat_ff <= RD_ZERO;
    end
  end

  // ack one cycle after the strobe, dropped the next cycle
  always_ff @(posedge mclk)
  begin
    if (rst)
      ack_ff <= 1'b0;
    else
      ack_ff <= wb_req;
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign pc_load = pc_ff;
  assign pc_load_valid = pcv_ff;
  assign stack_reset_req = rstreq_ff;
  assign shadow_out = shadow_ff;
  assign restore_shadow = restore_ff;
  assign prog_data = pdat_ff;
endmodule : ras_stack

// File: bench/ras_properties.sv
`timescale 1ns/1ps
module ras_properties
  import ras_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic big_mem,
  input wire ras_op_t op,
  input wire ras_shadow_t live_regs,
  input wire ras_shadow_t shadow_out,
  input wire logic restore_shadow,
  input wire logic pc_load_valid,
  input wire logic [PC_W-1:0] prog_addr,
  input wire logic [15:0] prog_data,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // answers come exactly one cycle after their cause
  a_ack_next: assert property
    (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack");
  a_ack_once: assert property
    (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_ret_load: assert property
    (op.ret |=> pc_load_valid) else $error("no load");
  a_pop_quiet: assert property
    (op.pop && !op.ret |=> !pc_load_valid) else $error("pop load");
  a_fast_back: assert property
    (op.ret && op.fast |=> restore_shadow) else $error("no restore");
  a_irq_grab: assert property
    (op.irq_ack |=> shadow_out == $past(live_regs)) else $error("irq");
  a_call_grab: assert property
    (op.push && op.fast |=> shadow_out == $past(live_regs)) else $error("cs");
  a_fill_zero: assert property
    (big_mem && prog_addr >= MEM_BIG |=> prog_data == 16'h0)
    else $error("fill");
  c_ret: cover property (op.ret ##1 pc_load_valid);
  c_irq: cover property (op.irq_ack);
  c_bus: cover property (wb_ack_o);
endmodule : ras_properties
bind ras_stack ras_properties chk_i (
  .mclk(mclk),
  .rst(rst),
  .big_mem(big_mem),
  .op(op),
  .live_regs(live_regs),
  .shadow_out(shadow_out),
  .restore_shadow(restore_shadow),
  .pc_load_valid(pc_load_valid),
  .prog_addr(prog_addr),
  .prog_data(prog_data),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o)
);

// File: bench/ras_seq.sv
`timescale 1ns/1ps
module ras_seq
  import ras_pkg::*;
(
  output ras_op_t op, // stack request
  input wire logic mclk // core clock
);
  // one-edge pulse, idle edge after so pulses never merge
  task automatic req(input logic [4:0] k, input logic [PC_W-1:0] a);
    op <= {k, a};
    @(posedge mclk);
    op <= '0;
    @(posedge mclk);
  endtask : req
  initial op = '0;
endmodule : ras_seq

// File: bench/tb.sv
`timescale 1ns/1ps
module tb;
  import ras_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, por = 1'b1, big_mem = 1'b1, wb_ack_o;
  logic overflow_reset_en = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0, restore_shadow, pc_load_valid, stack_reset_req;
  logic [3:0] wb_sel_i = 4'h1;
  logic [PC_W-1:0] pc_load, prog_addr = 21'h1ffffe;
  logic [15:0] prog_rdata = 16'h5a5a, prog_data;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, rd;
  ras_op_t op;
  ras_shadow_t shadow_out, live_regs = 24'h112233;
  int n_errors = 0, compares = 0;
  // 20 mhz core clock
  always #25 mclk = ~mclk;
  ras_seq seq (.mclk, .op);
  ras_stack uut (
    .mclk(mclk),
    .rst(rst),
    .por(por),
    .overflow_reset_en(overflow_reset_en),
    .big_mem(big_mem),
    .op(op),
    .live_regs(live_regs),
    .shadow_out(shadow_out),
    .restore_shadow(restore_shadow),
    .pc_load(pc_load),
    .pc_load_valid(pc_load_valid),
    .stack_reset_req(stack_reset_req),
    .prog_addr(prog_addr),
    .prog_rdata(prog_rdata),
    .prog_data(prog_data),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o)
  );
  task automatic chk(input logic [31:0] e, g, input string s);
    compares++;
    if (g !== e) $display("BAD %s exp %h got %h", s, e, g);
    n_errors += int'(g !== e);
  endtask : chk
  // request held until ack is sampled, then one idle cycle
  task automatic bus(input logic w, input logic [7:0] a, d);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    {wb_adr_i, wb_dat_i} <= {24'h0, a, 24'h0, d};
    do @(posedge mclk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge mclk);
  endtask : bus
  task automatic rc(input logic [7:0] a, e, input string s);
    bus(1'b0, a, 8'h00);
    chk({24'h0, e}, rd, s);
  endtask : rc
  task automatic report_and_stop;
    if (n_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  // hang guard, well past the 80 or so cycles needed
  initial
  begin
    repeat (3000) @(posedge mclk);
    n_errors++;
    report_and_stop;
  end
  // stack traffic mixed with register accesses
  initial
  begin
    repeat (6) @(posedge mclk);
    {rst, por} <= 2'b00;
    rc(8'h00, 8'h00, "ptr");
    {big_mem, prog_addr} <= {1'b0, 21'h004000};
    repeat (2) @(posedge mclk);
    chk(32'h0, {16'h0, prog_data}, "fill small");
    big_mem <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(32'h5a5a, {16'h0, prog_data}, "fetch big");
    prog_addr <= 21'h1ffffe;
    repeat (2) @(posedge mclk);
    chk(32'h0, {16'h0, prog_data}, "fill big");
    seq.req(5'h10, 21'h000100);
    seq.req(5'h10, 21'h15a3c6);
    rc(8'h04, 8'hc6, "top_entry_low");
    rc(8'h0c, 8'h15, "top_entry_upper");
    bus(1'b1, 8'h08, 8'h44);
    seq.req(5'h04, 21'h0);
    chk(32'h3544c6, {pc_load_valid, pc_load}, "ret");
    seq.req(5'h11, 21'h0);
    live_regs <= 24'h445566;
    seq.req(5'h08, 21'h0);
    seq.req(5'h05, 21'h0);
    chk(32'h1445566, {restore_shadow, shadow_out}, "fast");
    seq.req(5'h02, 21'h0);
    seq.req(5'h02, 21'h0);
    seq.req(5'h04, 21'h0);
    chk(32'h200000, {pc_load_valid, pc_load}, "unf");
    bus(1'b1, 8'h00, 8'hc0);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    rc(8'h00, 8'h40, "ptr");
    bus(1'b1, 8'h00, 8'h1d);
    repeat (3) seq.req(5'h10, 21'h000abc);
    rc(8'h00, 8'h9f, "ptr");
    overflow_reset_en <= 1'b1;
    bus(1'b1, 8'h00, 8'h1e);
    seq.req(5'h10, 21'h000300);
    chk(32'h1, stack_reset_req, "ovf");
    rc(8'h04, 8'h02, "top_entry_low");
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    rc(8'h00, 8'h80, "ptr");
    rc(8'h10, 8'h00, "gap");
    report_and_stop;
  end
endmodule : tb
